// file: rtl/ssf_defs.svh
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define SSF_ADDR_W        8
`define SSF_OFF_CTRL      8'h00
`define SSF_OFF_STATUS    8'h04
`define SSF_OFF_DATA      8'h08
`define SSF_OFF_IRQ_STAT  8'h0C
`define SSF_OFF_IRQ_MASK  8'h10

// ****************************************************************
// Control register fields
// ****************************************************************
`define SSF_CTRL_W        3
`define SSF_CTRL_ON       0
`define SSF_CTRL_ENH      1
`define SSF_CTRL_FRAMED   2
`define SSF_CTRL_RESET    3'h0

// ****************************************************************
// Status register fields
// ****************************************************************
`define SSF_ST_RXCNT_HI   28
`define SSF_ST_RXCNT_LO   24
`define SSF_ST_TXCNT_HI   20
`define SSF_ST_TXCNT_LO   16
`define SSF_ST_ACTIVE     11
`define SSF_ST_UNDERRUN   8
`define SSF_ST_SH_EMPTY   7
`define SSF_ST_RX_OVF     6
`define SSF_ST_RX_EMPTY   5
`define SSF_ST_TX_EMPTY   3
`define SSF_ST_TX_FULL    1
`define SSF_ST_RX_FULL    0
`define SSF_ST_RESET      32'h0000_0008
`define SSF_ST_RSVD_MASK  32'hE0E0_F614
`define SSF_CNT_W         5

// ****************************************************************
// Interrupt status / mask fields
// ****************************************************************
`define SSF_IRQ_W         4
`define SSF_IRQ_RX_WORD   0
`define SSF_IRQ_TX_EMPTY  1
`define SSF_IRQ_RX_OVF    2
`define SSF_IRQ_UNDERRUN  3
`define SSF_IRQ_RESET     4'h0

// ****************************************************************
// Sizes
// ****************************************************************
`define SSF_WORD_W        8
`define SSF_FIFO_DEPTH    16

`endif

// file: rtl/ssf_fifo.sv
`timescale 1ns/1ps

// ****************************************************************
// Element store: full depth when enhanced, else a single word
// ****************************************************************
module ssf_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input wire logic    mclk,
	input wire logic    rst_n,
	ssf_fifo_if.store   port
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CAP_FULL = (AW+1)'(DEPTH);
	localparam logic [AW:0] CAP_ONE  = (AW+1)'(1);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wptr_reg;
	logic [AW:0]  rptr_reg;

	// Extra pointer bit tells full from empty
	wire [AW:0] count_w = wptr_reg - rptr_reg;
	wire [AW:0] cap_w   = port.enh ? CAP_FULL : CAP_ONE;
	wire        empty_w = (wptr_reg == rptr_reg);
	wire        full_w  = (count_w >= cap_w);
	wire        push_ok = port.push && !full_w;
	wire        pop_ok  = port.pop && !empty_w;

	assign port.count = count_w;
	assign port.empty = empty_w;
	assign port.full  = full_w;
	assign port.rdata = mem[rptr_reg[AW-1:0]];

	// Pointers; a flush drops every held word at once
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else if (port.flush) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else begin
			if (push_ok)
				wptr_reg <= wptr_reg + CAP_ONE;
			if (pop_ok)
				rptr_reg <= rptr_reg + CAP_ONE;
		end
	end

	// Storage needs no reset
	always_ff @(posedge mclk) begin
		if (push_ok && !port.flush)
			mem[wptr_reg[AW-1:0]] <= port.wdata;
	end

	// A push into a full store must leave the write pointer alone
	AST_FIFO_NO_OVERFILL: assert property (@(posedge mclk) disable iff (!rst_n)
		port.push && full_w && !port.flush |=> (wptr_reg == $past(wptr_reg)))
		else $error("Element store took a word while full");

endmodule : ssf_fifo

// file: rtl/ssf_fifo_if.sv
`timescale 1ns/1ps

// ****************************************************************
// Buffer port between the port logic and one element store
// ****************************************************************
interface ssf_fifo_if #(
	parameter int W     = 8,
	parameter int DEPTH = 16
);
	localparam int AW = $clog2(DEPTH);

	logic         push;
	logic [W-1:0] wdata;
	logic         pop;
	logic         flush;
	logic         enh;
	logic [W-1:0] rdata;
	logic [AW:0]  count;
	logic         empty;
	logic         full;

	modport user  (output push, wdata, pop, flush, enh, input rdata, count, empty, full);
	modport store (input push, wdata, pop, flush, enh, output rdata, count, empty, full);
endinterface : ssf_fifo_if

// file: rtl/ssf_pkg.sv
package ssf_pkg;

	// Shift register occupancy
	typedef enum logic {
		SSF_EMPTY,
		SSF_LOADED
	} ssf_shift_e;

	typedef logic [31:0] ssf_word_t;

endpackage : ssf_pkg

// file: rtl/ssf_top.sv
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "ssf_defs.svh"

// Functional notes
// - Receive element count at bits 28-24, enhanced only
// - Transmit element count at bits 20-16, enhanced only
// - Bit 11 high while port is busy
// - Bit 8 flags transmit underrun in framed mode
// - Underrun clears only by switching port off
// - Bit 7 shows empty shift register, enhanced
// - Word arriving into full buffer: dropped, bit 6
// - Overflow set by hardware, cleared writing zero
// - Bit 5 high when receive pointers are equal, enhanced only
// - Transmit empty sets when the last held word enters shifter
// - Transmit empty clears on data buffer write while port is on
// - Unused status bits always read zero
module ssf_top #(
	parameter int WORD_W = `SSF_WORD_W,
	parameter int DEPTH  = `SSF_FIFO_DEPTH
) (
	input  wire logic                   mclk,
	input  wire logic                   arst_n,
	input  wire logic [`SSF_ADDR_W-1:0] addr,
	input  wire logic [31:0]            wr_data,
	input  wire logic                   wr_en,
	input  wire logic                   rd_en,
	output logic      [31:0]            rd_data,
	input  wire logic                   sck,
	input  wire logic                   ss_n,
	input  wire logic                   sdi,
	output logic                        sdo,
	output logic                        sdo_oe,
	output logic                        irq
);
	localparam int CW = `SSF_CNT_W;
	localparam int BW = $clog2(WORD_W);
	localparam logic [BW-1:0] LAST_BIT = BW'(WORD_W - 1);
	localparam logic [BW-1:0] BIT_ONE  = BW'(1);

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic [1:0] rst_sync_reg;
	wire        rst_n = rst_sync_reg[1];

	// Assert at once, release on the clock
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'h1};
	end

	// ****************************************************************
	// Link pin synchronisers, bit order {sck, ss_n, sdi}
	// ****************************************************************
	logic [2:0] link_s1_reg;
	logic [2:0] link_s2_reg;
	logic       sck_s3_reg;

	// Third sck stage feeds only the edge finder
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			link_s1_reg <= 3'h2;
			link_s2_reg <= 3'h2;
			sck_s3_reg  <= 1'h0;
		end else begin
			link_s1_reg <= {sck, ss_n, sdi};
			link_s2_reg <= link_s1_reg;
			sck_s3_reg  <= link_s2_reg[2];
		end
	end

	// ****************************************************************
	// Registers and buffers
	// ****************************************************************
	logic [`SSF_CTRL_W-1:0] ctrl_reg;
	logic [`SSF_IRQ_W-1:0]  irq_stat_reg;
	logic [`SSF_IRQ_W-1:0]  irq_mask_reg;
	logic                   underrun_reg;
	logic                   rx_ovf_reg;
	logic                   tbe_prev_reg;
	ssf_pkg::ssf_shift_e    shift_st_reg;
	logic [WORD_W-1:0]      tx_sh_reg;
	logic [WORD_W-1:0]      rx_sh_reg;
	logic [BW-1:0]          bit_cnt_reg;
	ssf_pkg::ssf_word_t     status_w;

	ssf_fifo_if #(.W(WORD_W), .DEPTH(DEPTH)) rx_if ();
	ssf_fifo_if #(.W(WORD_W), .DEPTH(DEPTH)) tx_if ();

	ssf_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_rx_fifo (
		.mclk  (mclk),
		.rst_n (rst_n),
		.port  (rx_if.store)
	);

	ssf_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_tx_fifo (
		.mclk  (mclk),
		.rst_n (rst_n),
		.port  (tx_if.store)
	);

	// ****************************************************************
	// Decodes
	// ****************************************************************
	wire on_w        = ctrl_reg[`SSF_CTRL_ON];
	wire enh_w       = ctrl_reg[`SSF_CTRL_ENH];
	wire framed_w    = ctrl_reg[`SSF_CTRL_FRAMED];
	wire sel_w       = on_w && !link_s2_reg[1];
	wire sdi_w       = link_s2_reg[0];
	wire sck_rise_w  = link_s2_reg[2] && !sck_s3_reg;
	wire sck_fall_w  = !link_s2_reg[2] && sck_s3_reg;
	wire sh_empty_w  = (shift_st_reg == ssf_pkg::SSF_EMPTY);
	wire word_end_w  = sel_w && sck_rise_w && (bit_cnt_reg == LAST_BIT);
	wire wr_ctrl_w   = wr_en && (addr == `SSF_OFF_CTRL);
	wire wr_stat_w   = wr_en && (addr == `SSF_OFF_STATUS);
	wire wr_data_w   = wr_en && (addr == `SSF_OFF_DATA);
	wire wr_mask_w   = wr_en && (addr == `SSF_OFF_IRQ_MASK);
	wire rd_data_w   = rd_en && (addr == `SSF_OFF_DATA);
	wire rd_irq_w    = rd_en && (addr == `SSF_OFF_IRQ_STAT);
	// Next word may enter the shifter only between words
	wire load_w      = sel_w && sh_empty_w && (bit_cnt_reg == '0) && !tx_if.empty;
	// Clocking starts a word with nothing to send
	wire under_evt_w = sel_w && sck_rise_w && sh_empty_w && (bit_cnt_reg == '0)
		&& tx_if.empty && framed_w;
	wire ovf_evt_w   = word_end_w && rx_if.full;
	wire ovf_clr_w   = wr_stat_w && !wr_data[`SSF_ST_RX_OVF];
	wire tbe_rise_w  = tx_if.empty && !tbe_prev_reg;
	wire active_w    = sel_w || (bit_cnt_reg != '0);
	wire [CW-1:0] rx_cnt_w = CW'(rx_if.count);
	wire [CW-1:0] tx_cnt_w = CW'(tx_if.count);
	wire [`SSF_IRQ_W-1:0] irq_evt_w = {under_evt_w, ovf_evt_w, tbe_rise_w, word_end_w};

	// Buffer steering; switching off empties both stores
	assign rx_if.push  = word_end_w && !rx_if.full;
	assign rx_if.wdata = {rx_sh_reg[WORD_W-2:0], sdi_w};
	assign rx_if.pop   = rd_data_w;
	assign rx_if.flush = !on_w;
	assign rx_if.enh   = enh_w;
	assign tx_if.push  = wr_data_w;
	assign tx_if.wdata = wr_data[WORD_W-1:0];
	assign tx_if.pop   = load_w;
	assign tx_if.flush = !on_w;
	assign tx_if.enh   = enh_w;

	// ****************************************************************
	// Status word
	// ****************************************************************
	// Every bit not set below stays zero
	always_comb begin
		status_w = '0;
		status_w[`SSF_ST_RXCNT_HI:`SSF_ST_RXCNT_LO] = enh_w ? rx_cnt_w : '0;
		status_w[`SSF_ST_TXCNT_HI:`SSF_ST_TXCNT_LO] = enh_w ? tx_cnt_w : '0;
		status_w[`SSF_ST_ACTIVE]   = active_w;
		status_w[`SSF_ST_UNDERRUN] = underrun_reg;
		status_w[`SSF_ST_SH_EMPTY] = enh_w && sh_empty_w;
		status_w[`SSF_ST_RX_OVF]   = rx_ovf_reg;
		status_w[`SSF_ST_RX_EMPTY] = enh_w && rx_if.empty;
		status_w[`SSF_ST_TX_EMPTY] = tx_if.empty;
		status_w[`SSF_ST_TX_FULL]  = tx_if.full;
		status_w[`SSF_ST_RX_FULL]  = !rx_if.empty;
	end

	// Read selection; unmapped addresses read zero
	wire [31:0] rd_mux_w =
		(addr == `SSF_OFF_CTRL)     ? {29'h0, ctrl_reg} :
		(addr == `SSF_OFF_STATUS)   ? status_w :
		(addr == `SSF_OFF_DATA)     ? 32'(rx_if.rdata) :
		(addr == `SSF_OFF_IRQ_STAT) ? {28'h0, irq_stat_reg} :
		(addr == `SSF_OFF_IRQ_MASK) ? {28'h0, irq_mask_reg} : 32'h0000_0000;

	// ****************************************************************
	// Software registers and flags
	// ****************************************************************
	// Control and mask are plain storage
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg     <= `SSF_CTRL_RESET;
			irq_mask_reg <= `SSF_IRQ_RESET;
		end else begin
			if (wr_ctrl_w)
				ctrl_reg <= wr_data[`SSF_CTRL_W-1:0];
			if (wr_mask_w)
				irq_mask_reg <= wr_data[`SSF_IRQ_W-1:0];
		end
	end

	// Sticky flags: a same-cycle event beats any clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			underrun_reg <= 1'h0;
			rx_ovf_reg   <= 1'h0;
			irq_stat_reg <= `SSF_IRQ_RESET;
			tbe_prev_reg <= 1'h1;
		end else begin
			underrun_reg <= on_w && (underrun_reg || under_evt_w);
			rx_ovf_reg   <= ovf_evt_w || (rx_ovf_reg && !ovf_clr_w);
			irq_stat_reg <= (rd_irq_w ? `SSF_IRQ_RESET : irq_stat_reg) | irq_evt_w;
			tbe_prev_reg <= tx_if.empty;
		end
	end

	// Registered outputs; read data stands for one cycle only
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 32'h0000_0000;
			irq     <= 1'h0;
		end else begin
			rd_data <= rd_en ? rd_mux_w : 32'h0000_0000;
			irq     <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// ****************************************************************
	// Serial shifter, clock idle low, sample on rise, MSB first
	// ****************************************************************
	// Loaded word is held until its last bit is sampled
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_st_reg <= ssf_pkg::SSF_EMPTY;
			tx_sh_reg    <= '0;
		end else if (!on_w) begin
			shift_st_reg <= ssf_pkg::SSF_EMPTY;
			tx_sh_reg    <= '0;
		end else begin
			unique case (shift_st_reg)
				ssf_pkg::SSF_EMPTY: begin
					if (load_w) begin
						tx_sh_reg    <= tx_if.rdata;
						shift_st_reg <= ssf_pkg::SSF_LOADED;
					end
				end
				ssf_pkg::SSF_LOADED: begin
					if (word_end_w)
						shift_st_reg <= ssf_pkg::SSF_EMPTY;
					else if (sel_w && sck_fall_w)
						tx_sh_reg <= {tx_sh_reg[WORD_W-2:0], 1'h0};
				end
			endcase
		end
	end

	// Deselect mid-word abandons the partial word
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_reg <= '0;
			rx_sh_reg   <= '0;
		end else if (!sel_w) begin
			bit_cnt_reg <= '0;
		end else if (sck_rise_w) begin
			bit_cnt_reg <= word_end_w ? '0 : bit_cnt_reg + BIT_ONE;
			rx_sh_reg   <= {rx_sh_reg[WORD_W-2:0], sdi_w};
		end
	end

	// Pin drive; an underrun word shifts out zeros
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sdo    <= 1'h0;
			sdo_oe <= 1'h0;
		end else begin
			sdo    <= !sh_empty_w && tx_sh_reg[WORD_W-1];
			sdo_oe <= sel_w;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_status_read;
		rd_en && (addr == `SSF_OFF_STATUS);
	endsequence

	sequence s_word_full;
		word_end_w && rx_if.full;
	endsequence

	AST_RXCNT_SHOWN: assert property (s_status_read ##0 enh_w |=>
		rd_data[`SSF_ST_RXCNT_HI:`SSF_ST_RXCNT_LO] == $past(rx_cnt_w))
		else $error("Receive count read back wrong");
	AST_TXCNT_HIDDEN: assert property (s_status_read ##0 !enh_w |=>
		rd_data[`SSF_ST_TXCNT_HI:`SSF_ST_TXCNT_LO] == 5'h00)
		else $error("Transmit count visible outside enhanced mode");
	AST_BUSY_SHOWN: assert property (s_status_read ##0 sel_w |=> rd_data[`SSF_ST_ACTIVE])
		else $error("Busy bit low during a selected transfer");
	AST_UNDERRUN_SET: assert property (under_evt_w |=> underrun_reg)
		else $error("Underrun not flagged");
	AST_UNDERRUN_HOLD: assert property (underrun_reg && on_w |=> underrun_reg)
		else $error("Underrun cleared while port stays on");
	// A control write at the last bit may change the mode, so it is left out
	AST_SHIFTER_EMPTY: assert property (word_end_w && enh_w && !wr_ctrl_w |=>
		status_w[`SSF_ST_SH_EMPTY])
		else $error("Shifter empty bit low after last bit");
	AST_OVF_DROP: assert property (s_word_full |-> !rx_if.push ##1 rx_ovf_reg)
		else $error("Overflowing word kept or flag not set");
	AST_OVF_NO_SW_SET: assert property (!rx_ovf_reg && !ovf_evt_w |=> !rx_ovf_reg)
		else $error("Overflow flag set without an overflow");
	AST_RX_EMPTY_PTR: assert property (enh_w && rx_if.push && !rx_if.flush |=>
		!status_w[`SSF_ST_RX_EMPTY])
		else $error("Receive empty bit high after a push");
	AST_TBE_SET: assert property (load_w && (tx_if.count == 1) && !tx_if.push |=>
		status_w[`SSF_ST_TX_EMPTY])
		else $error("Transmit empty not set after move to shifter");
	AST_TBE_CLR: assert property (wr_data_w && on_w |=> !status_w[`SSF_ST_TX_EMPTY])
		else $error("Transmit empty not cleared by data write");
	AST_RSVD_ZERO: assert property (s_status_read |=> (rd_data & `SSF_ST_RSVD_MASK) == 0)
		else $error("Reserved status bit read as one");
	AST_RESET_VALUE: assert property ($rose(rst_n) |-> status_w == `SSF_ST_RESET)
		else $error("Status differs from reset value");
	AST_FULL_BITS: assert property (s_status_read |=>
		rd_data[`SSF_ST_RX_FULL] == $past(!rx_if.empty)
		&& rd_data[`SSF_ST_TX_FULL] == $past(tx_if.full))
		else $error("Buffer full bits read back wrong");

endmodule : ssf_top

// file: testbench/spi_status_flags_tb.sv
`timescale 1ns/1ps
`include "ssf_defs.svh"

// ****************************************************************
// Status flag bench
// ****************************************************************
module spi_status_flags_tb;
	logic        mclk;
	logic        arst_n;
	logic        wr_en;
	logic        rd_en;
	logic        sdo;
	logic        sdo_oe;
	logic        irq;
	logic        sck;
	logic        ss_n;
	logic        sdi;
	logic [7:0]  addr;
	logic [7:0]  rx;
	logic [31:0] wr_data;
	logic [31:0] rd_data;
	logic [31:0] v;
	int          failures;
	int          n_tests;
	int          cyc;

	ssf_top dut (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sck(sck), .ss_n(ss_n),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .irq(irq));

	ssf_peer peer (.sck(sck), .ss_n(ss_n), .sdi(sdi), .sdo(sdo));

	// 250 MHz clock
	initial begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end

	// Hang guard: the tests need about a thousand cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end

	// Bus write: one strobe cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'h1;
		@(posedge mclk);
		wr_en <= 1'h0;
	endtask : wr

	// Bus read: data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge mclk);
		rd_en <= 1'h0;
		#1;
		d = rd_data;
	endtask : rd

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp);
	endtask : rchk

	// Interrupt has a one-cycle lag, so let it settle first
	task automatic ichk(input logic exp);
		repeat (3) @(posedge mclk);
		#1;
		chk({31'h0, irq}, {31'h0, exp});
	endtask : ichk

	// Frame from the peer, then time for the push to land
	task automatic frame(input logic [7:0] tx);
		peer.xfer(tx, rx);
		repeat (8) @(posedge mclk);
	endtask : frame

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask : tdone

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	// Main sequence
	initial begin
		failures = 0;
		n_tests = 0;
		cyc = 0;
		arst_n = 1'h0;
		wr_en = 1'h0;
		rd_en = 1'h0;
		addr = 8'h00;
		wr_data = 32'h0000_0000;
		repeat (2) @(posedge mclk);
		arst_n <= 1'h1;
		repeat (3) @(posedge mclk);
		rchk(`SSF_OFF_STATUS, 32'h0000_0008);
		rchk(`SSF_OFF_CTRL, 32'h0000_0000);
		wr(8'h14, 32'hFFFF_FFFF);
		rchk(8'h14, 32'h0000_0000);
		wr(`SSF_OFF_STATUS, 32'hFFFF_FFFF);
		rchk(`SSF_OFF_STATUS, 32'h0000_0008);
		tdone("reset");

		// Enhanced mode: one word each way
		wr(`SSF_OFF_CTRL, 32'h0000_0003);
		wr(`SSF_OFF_DATA, 32'h0000_00A5);
		rchk(`SSF_OFF_STATUS, 32'h0001_00A0);
		fork
			frame(8'h3C);
			begin
				repeat (60) @(posedge mclk);
				rd(`SSF_OFF_STATUS, v);
				chk(v & 32'h0000_0800, 32'h0000_0800);
				chk(v & 32'h0000_0080, 32'h0000_0000);
				chk({31'h0, sdo_oe}, 32'h0000_0001);
			end
		join
		chk({24'h0, rx}, 32'h0000_00A5);
		chk({31'h0, sdo_oe}, 32'h0000_0000);
		rchk(`SSF_OFF_STATUS, 32'h0100_0089);
		ichk(1'h0);
		rchk(`SSF_OFF_IRQ_STAT, 32'h0000_0003);
		rchk(`SSF_OFF_DATA, 32'h0000_003C);
		rchk(`SSF_OFF_STATUS, 32'h0000_00A8);
		tdone("stream");

		// Single-word mode: second word is dropped
		wr(`SSF_OFF_CTRL, 32'h0000_0001);
		wr(`SSF_OFF_IRQ_MASK, 32'h0000_0004);
		frame(8'h11);
		frame(8'h22);
		rchk(`SSF_OFF_STATUS, 32'h0000_0049);
		ichk(1'h1);
		wr(`SSF_OFF_STATUS, 32'hFFFF_FFFF);
		rchk(`SSF_OFF_STATUS, 32'h0000_0049);
		wr(`SSF_OFF_STATUS, 32'h0000_0000);
		rchk(`SSF_OFF_STATUS, 32'h0000_0009);
		rchk(`SSF_OFF_DATA, 32'h0000_0011);
		rchk(`SSF_OFF_IRQ_STAT, 32'h0000_0005);
		ichk(1'h0);
		tdone("overflow");

		// Framed mode with nothing to send
		wr(`SSF_OFF_CTRL, 32'h0000_0005);
		wr(`SSF_OFF_IRQ_MASK, 32'h0000_0000);
		frame(8'h55);
		rchk(`SSF_OFF_STATUS, 32'h0000_0109);
		wr(`SSF_OFF_CTRL, 32'h0000_0005);
		rchk(`SSF_OFF_STATUS, 32'h0000_0109);
		wr(`SSF_OFF_CTRL, 32'h0000_0000);
		wr(`SSF_OFF_CTRL, 32'h0000_0005);
		rchk(`SSF_OFF_STATUS, 32'h0000_0008);
		tdone("underrun");

		// Fill the transmit store past its depth
		wr(`SSF_OFF_CTRL, 32'h0000_0003);
		for (int i = 0; i < 17; i++) begin
			wr(`SSF_OFF_DATA, i);
		end
		rchk(`SSF_OFF_STATUS, 32'h0010_00A2);
		wr(`SSF_OFF_CTRL, 32'h0000_0000);
		rchk(`SSF_OFF_STATUS, 32'h0000_0008);
		tdone("full");

		// Reset in mid-run returns every flag to its start value
		wr(`SSF_OFF_CTRL, 32'h0000_0003);
		wr(`SSF_OFF_DATA, 32'h0000_005A);
		rchk(`SSF_OFF_STATUS, 32'h0001_00A0);
		@(posedge mclk);
		arst_n <= 1'h0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'h1;
		repeat (3) @(posedge mclk);
		rchk(`SSF_OFF_STATUS, 32'h0000_0008);
		rchk(`SSF_OFF_CTRL, 32'h0000_0000);
		tdone("rerun");
		conclude();
	end
endmodule : spi_status_flags_tb

// file: testbench/ssf_peer.sv
`timescale 1ns/1ps

// ****************************************************************
// Serial master peer: mode 0, MSB first, eight-bit frames
// ****************************************************************
module ssf_peer (
	output logic      sck,
	output logic      ss_n,
	output logic      sdi,
	input  wire logic sdo
);
	// Idle: deselected, clock parked low
	initial begin
		sck = 1'h0;
		ss_n = 1'h1;
		sdi = 1'h0;
	end

	// One frame; the clock runs only while selected
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		#7;
		ss_n = 1'h0;
		#80;
		for (int i = 7; i >= 0; i--) begin
			sdi = tx[i];
			#40;
			sck = 1'h1;
			rx[i] = sdo;
			#40;
			sck = 1'h0;
		end
		#40;
		ss_n = 1'h1;
		// Released line shows the inverse, never a held value
		sdi = ~sdi;
	endtask : xfer
endmodule : ssf_peer
